// ===== tacc_alarm_core.sv
// Purpose: configuration, limit registers and alarm pin of the thermal monitor
// Assumes: a serial front end turns bus frames into tacc_req_t accesses
// Notes: the alarm pin is open drain when active low, push-pull when active high
//
// Function
// RQ1 - shutdown stops conversion, alarms and reading updates
// RQ2 - shutdown set refused while locked, clear always
// RQ3 - registers answer normally while shut down
// RQ4 - critical lock guards critical limit until reset
// RQ5 - window lock guards upper/lower limits until reset
// RQ6 - clear bit releases alarm, self-clears, reads zero
// RQ7 - clear bit ignored in comparator mode
// RQ8 - status bit shows alarm asserted
// RQ9 - enable gates alarm, frozen under locks
// RQ10 - critical-only selects sources, frozen by window lock
// RQ11 - polarity picks asserted pin level
// RQ12 - mode bit picks comparator or interrupt
// RQ13 - limits and temperature are two's complement
// RQ14 - bits 12..2 defined in every register
// RQ15 - compare bits 12..2, read full resolution
// RQ16 - host zeroes limit bit 2 at half-degree
// RQ17 - host writes zero to unused limit bits
// RQ18 - upper limit at pointer 02 resets zero
// RQ19 - upper limit crossing asserts enabled alarm
// RQ20 - upper limit read-only under window lock
// RQ21 - hysteresis codes none, 1.5, 3, 6 degrees
// RQ22 - hysteresis frozen while either lock set
// RQ23 - comparator follows, interrupt latches until clear
module tacc_alarm_core #(
   parameter logic [15:0] MFR_ID = 16'h0001, // arbitrary value
   parameter logic [15:0] DEV_REV = 16'h0100 // arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input tacc_pkg::tacc_req_t acc_req,
   output logic [15:0] acc_rdata_q,
   input tacc_pkg::tacc_sample_t conv_sample,
   output logic conv_run,
   input wire logic alarm_pin_i,
   output logic alarm_pin_o,
   output logic alarm_pin_oe
);
   import tacc_pkg::*;

   logic [7:0] ptr_q;
   logic mode_q;
   logic pol_q;
   logic conly_q;
   logic en_q;
   logic wlock_q;
   logic clock_q;
   logic power_down_bit_q;
   logic [1:0] hysteresis_field_q;
   logic [10:0] lim_q [NUM_CH];
   logic [12:0] temp_q;
   logic [4:0] res_q;
   logic alarm_q;
   logic cond_q;
   logic [NUM_CH-1:0] flag;
   logic [4:0] hysteresis_field_amt;
   logic cfg_wr;
   logic any_lock;
   logic clear_req;
   logic sample_ok;
   logic cond_c;
   logic [15:0] cfg_rd;
   logic [12:0] temp_rd;
   logic [15:0] rd_c;

   // write strobes use the pointer latched by an earlier pointer write
   assign cfg_wr = acc_req.wr && ptr_q == PTR_CFG;
   assign any_lock = wlock_q | clock_q;
   assign clear_req = cfg_wr && acc_req.wdata[CFG_CLEAR] && mode_q; // RQ6 RQ7
   assign sample_ok = conv_sample.valid && !power_down_bit_q; // RQ1
   assign conv_run = !power_down_bit_q; // RQ1

   // address pointer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ptr_q <= 8'h00;
      end else if (acc_req.ptr_wr) begin
         ptr_q <= acc_req.ptr;
      end
   end

   // polarity and mode are always writable
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_q <= RST_CFG[CFG_MODE];
         pol_q <= RST_CFG[CFG_POL];
      end else if (cfg_wr) begin
         mode_q <= acc_req.wdata[CFG_MODE]; // RQ12
         pol_q <= acc_req.wdata[CFG_POL]; // RQ11
      end
   end

   // locks only ever set; cleared by reset alone
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wlock_q <= RST_CFG[CFG_WLOCK];
         clock_q <= RST_CFG[CFG_CLOCK];
      end else if (cfg_wr) begin
         if (acc_req.wdata[CFG_WLOCK]) begin
            wlock_q <= 1'b1; // RQ5
         end
         if (acc_req.wdata[CFG_CLOCK]) begin
            clock_q <= 1'b1; // RQ4
         end
      end
   end

   // fields frozen by locks, judged on the lock state before this write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_q <= RST_CFG[CFG_EN];
         hysteresis_field_q <= RST_CFG[CFG_HYSTERESIS_FIELD_LO+1:CFG_HYSTERESIS_FIELD_LO];
         conly_q <= RST_CFG[CFG_CONLY];
      end else if (cfg_wr) begin
         if (!any_lock) begin
            en_q <= acc_req.wdata[CFG_EN]; // RQ9
            hysteresis_field_q <= acc_req.wdata[CFG_HYSTERESIS_FIELD_LO+1:CFG_HYSTERESIS_FIELD_LO]; // RQ22
         end
         if (!wlock_q) begin
            conly_q <= acc_req.wdata[CFG_CONLY]; // RQ10
         end
      end
   end

   // shutdown: set refused under a lock, clear taken any time
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         power_down_bit_q <= RST_CFG[CFG_POWER_DOWN_BIT];
      end else if (cfg_wr) begin
         if (!acc_req.wdata[CFG_POWER_DOWN_BIT]) begin
            power_down_bit_q <= 1'b0; // RQ2
         end else if (!any_lock) begin
            power_down_bit_q <= 1'b1; // RQ2
         end
      end
   end

   // limit registers, unused bits dropped so they read zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            lim_q[i] <= RST_LIMIT[TMP_CMP_HI:TMP_CMP_LO]; // RQ18
         end
      end else if (acc_req.wr) begin
         if (ptr_q == PTR_UPPER && !wlock_q) begin
            lim_q[CH_UPPER] <= acc_req.wdata[TMP_CMP_HI:TMP_CMP_LO]; // RQ20
         end
         if (ptr_q == PTR_LOWER && !wlock_q) begin
            lim_q[CH_LOWER] <= acc_req.wdata[TMP_CMP_HI:TMP_CMP_LO]; // RQ5
         end
         if (ptr_q == PTR_CRIT && !clock_q) begin
            lim_q[CH_CRIT] <= acc_req.wdata[TMP_CMP_HI:TMP_CMP_LO]; // RQ4
         end
      end
   end

   // resolution code register; bits 2..0 are test bits mirrored to capabilities
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         res_q <= RST_RES;
      end else if (acc_req.wr && ptr_q == PTR_RES) begin
         res_q <= acc_req.wdata[4:0];
      end
   end

   // latest reading, held while shut down
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         temp_q <= 13'h0000;
      end else if (sample_ok) begin
         temp_q <= conv_sample.value; // RQ1 RQ13
      end
   end

   // hysteresis code to quarter degrees
   always_comb begin
      case (hysteresis_field_q)
         2'b00: hysteresis_field_amt = HYSTERESIS_FIELD_Q0;
         2'b01: hysteresis_field_amt = HYSTERESIS_FIELD_Q1;
         2'b10: hysteresis_field_amt = HYSTERESIS_FIELD_Q2;
         default: hysteresis_field_amt = HYSTERESIS_FIELD_Q3;
      endcase
   end

   // one comparator per limit on the quarter-degree window only
   for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
      tacc_limit_cmp #(
         .IS_LOW(g == CH_LOWER)
      ) u_cmp (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .sample_en(sample_ok),
         .temp(conv_sample.value[TMP_CMP_HI:TMP_CMP_LO]), // RQ15
         .limit(lim_q[g]),
         .hysteresis_field(hysteresis_field_amt),
         .flag_q(flag[g])
      );
   end

   // alarm sources; upper-limit crossing counts in both directions
   assign cond_c = conly_q ? flag[CH_CRIT] : |flag; // RQ10 RQ19

   // previous condition, to see a new event in interrupt mode
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cond_q <= 1'b0;
      end else if (!power_down_bit_q) begin
         cond_q <= cond_c;
      end
   end

   // alarm state: frozen in shutdown unless disabled, new event wins over clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
      end else if (!en_q) begin
         alarm_q <= 1'b0; // RQ9
      end else if (!power_down_bit_q) begin
         if (!mode_q) begin
            alarm_q <= cond_c; // RQ23 RQ7
         end else if (cond_c != cond_q) begin
            alarm_q <= 1'b1; // RQ23 RQ19
         end else if (clear_req) begin
            alarm_q <= 1'b0; // RQ6
         end
      end
   end

   // pin drive: active low pulls down only, active high drives both levels
   assign alarm_pin_o = alarm_q ? pol_q : ~pol_q; // RQ11
   assign alarm_pin_oe = alarm_q | pol_q;

   // config readback; clear bit always reads zero
   assign cfg_rd = {5'h00, hysteresis_field_q, power_down_bit_q, clock_q, wlock_q, 1'b0, alarm_q, en_q, conly_q,
                    pol_q, mode_q}; // RQ8 RQ6

   // reading masked to the selected resolution
   always_comb begin
      case (res_q[4:3])
         2'b00: temp_rd = {temp_q[12:3], 3'h0};
         2'b01: temp_rd = {temp_q[12:2], 2'h0};
         2'b10: temp_rd = {temp_q[12:1], 1'h0};
         default: temp_rd = temp_q;
      endcase
   end

   // read multiplexer, unmapped pointers read zero
   always_comb begin
      case (ptr_q)
         PTR_CAPS: rd_c = {8'h00, CAPS_TOP, res_q};
         PTR_CFG: rd_c = cfg_rd;
         PTR_UPPER: rd_c = {3'h0, lim_q[CH_UPPER], 2'h0}; // RQ14
         PTR_LOWER: rd_c = {3'h0, lim_q[CH_LOWER], 2'h0};
         PTR_CRIT: rd_c = {3'h0, lim_q[CH_CRIT], 2'h0};
         PTR_TEMP: rd_c = {flag[CH_CRIT], flag[CH_UPPER], flag[CH_LOWER], temp_rd}; // RQ15
         PTR_MFR: rd_c = MFR_ID;
         PTR_DEV: rd_c = DEV_REV;
         PTR_RES: rd_c = {11'h000, res_q};
         default: rd_c = 16'h0000;
      endcase
   end

   // read data register, served in shutdown as well
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         acc_rdata_q <= 16'h0000;
      end else if (acc_req.rd) begin
         acc_rdata_q <= rd_c; // RQ3
      end
   end

   // checks
   a_power_down_bit_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_wr && acc_req.wdata[CFG_POWER_DOWN_BIT] && any_lock && !power_down_bit_q |=> !power_down_bit_q) // RQ2
      else $error("shutdown set while locked");
   a_power_down_bit_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_wr && !acc_req.wdata[CFG_POWER_DOWN_BIT] |=> !power_down_bit_q) // RQ2
      else $error("shutdown clear not taken");
   a_power_down_bit_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
      power_down_bit_q && en_q ##1 power_down_bit_q |-> $stable(temp_q) && $stable(alarm_q)) // RQ1
      else $error("state moved during shutdown");
   a_crit_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clock_q |=> clock_q) // RQ4
      else $error("critical lock dropped");
   a_crit_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clock_q |=> $stable(lim_q[CH_CRIT])) // RQ4
      else $error("critical limit written while locked");
   a_upper_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wlock_q |=> $stable(lim_q[CH_UPPER]) && $stable(lim_q[CH_LOWER])) // RQ20
      else $error("window limit written while locked");
   a_upper_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      acc_req.wr && ptr_q == PTR_UPPER && !wlock_q
      |=> lim_q[CH_UPPER] == $past(acc_req.wdata[TMP_CMP_HI:TMP_CMP_LO])) // RQ18
      else $error("upper limit write lost");
   a_cfg_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      any_lock |=> $stable(en_q) && $stable(hysteresis_field_q)) // RQ9
      else $error("enable or hysteresis changed under lock");
   a_conly_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wlock_q |=> $stable(conly_q)) // RQ10
      else $error("critical-only changed under lock");
   a_comp_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !mode_q && en_q && !power_down_bit_q |=> alarm_q == $past(cond_c)) // RQ23
      else $error("comparator alarm does not follow condition");
   a_clear_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clear_req && !power_down_bit_q && cond_c == cond_q |=> !alarm_q) // RQ6
      else $error("clear did not release alarm");
   a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      acc_req.rd && ptr_q == PTR_CFG
      |=> acc_rdata_q[CFG_STS] == $past(alarm_q) && !acc_rdata_q[CFG_CLEAR]) // RQ8
      else $error("status readback wrong");
   a_pin_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alarm_q && !pol_q |-> alarm_pin_oe && !alarm_pin_o) // RQ11
      else $error("active-low pin not pulled down");

   c_int_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
      mode_q && alarm_q ##1 clear_req ##1 !alarm_q);
   c_comp_trip: cover property (@(posedge sys_clk) disable iff (!rst_n)
      !mode_q && !alarm_q ##1 alarm_q);
   c_lock_refuse: cover property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_wr && acc_req.wdata[CFG_POWER_DOWN_BIT] && any_lock);
   c_pin_seen: cover property (@(posedge sys_clk) disable iff (!rst_n)
      alarm_q && alarm_pin_i == pol_q);
endmodule : tacc_alarm_core

// ===== tacc_host_model.sv
// Purpose: far-side model: bus host issuing register accesses plus the converter feeding samples
// Assumes: one request pulse per cycle, pointer loaded before each word access
// Notes: the alarm wire carries a board pull-up, so a released pin reads high
module tacc_host_model (
   input wire logic sys_clk,
   output tacc_pkg::tacc_req_t acc_req,
   input wire logic [15:0] acc_rdata_q,
   output tacc_pkg::tacc_sample_t conv_sample,
   input wire logic alarm_pin_o,
   input wire logic alarm_pin_oe,
   output logic alarm_pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import tacc_pkg::*;

   // idle bus and converter at time zero
   initial begin
      acc_req = '0;
      conv_sample = '0;
   end

   // wire level: pull-up wins whenever the device lets go
   assign alarm_pin_i = alarm_pin_oe ? alarm_pin_o : 1'b1;

   // pointer load then one word write; callers keep unused limit bits at zero
   task automatic reg_write(input logic [7:0] p, input logic [15:0] d);
      @(posedge sys_clk);
      acc_req.ptr_wr <= 1'b1;
      acc_req.ptr <= p;
      @(posedge sys_clk);
      acc_req.ptr_wr <= 1'b0;
      acc_req.wr <= 1'b1;
      acc_req.wdata <= d;
      @(posedge sys_clk);
      acc_req.wr <= 1'b0;
      #1; // let the write land before the caller looks at outputs
   endtask : reg_write

   // pointer load then one word read, data taken once the read edge has landed
   task automatic reg_read(input logic [7:0] p, output logic [15:0] d);
      @(posedge sys_clk);
      acc_req.ptr_wr <= 1'b1;
      acc_req.ptr <= p;
      @(posedge sys_clk);
      acc_req.ptr_wr <= 1'b0;
      acc_req.rd <= 1'b1;
      @(posedge sys_clk);
      acc_req.rd <= 1'b0;
      #1 d = acc_rdata_q;
   endtask : reg_read

   // one conversion result, then wait past the alarm update
   task automatic put_sample(input logic [12:0] v);
      @(posedge sys_clk);
      conv_sample.valid <= 1'b1;
      conv_sample.value <= v;
      @(posedge sys_clk);
      conv_sample.valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : put_sample
endmodule : tacc_host_model

// ===== tacc_limit_cmp.sv
// Purpose: one limit comparator with hysteresis on falling (or rising) return
// Assumes: temperature and limit are the 11-bit quarter-degree compare window
// Notes: the flag only moves on an accepted sample
module tacc_limit_cmp #(
   parameter bit IS_LOW = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic [10:0] temp,
   input wire logic [10:0] limit,
   input wire logic [4:0] hysteresis_field,
   output logic flag_q
);
   import tacc_pkg::*;

   logic signed [12:0] t_s;
   logic signed [12:0] l_s;
   logic signed [12:0] h_s;
   logic signed [12:0] l_far;
   logic set_c;
   logic clr_c;

   // widen to avoid overflow when the hysteresis is applied
   assign t_s = {{2{temp[10]}}, temp};
   assign l_s = {{2{limit[10]}}, limit};
   assign h_s = {8'h00, hysteresis_field};
   assign l_far = IS_LOW ? 13'(l_s + h_s) : 13'(l_s - h_s);

   // low limit trips below and returns at limit plus band; others the mirror
   always_comb begin
      if (IS_LOW) begin
         set_c = t_s < l_s;
         clr_c = t_s >= l_far;
      end else begin
         set_c = t_s > l_s;
         clr_c = t_s <= l_far;
      end
   end

   // flag update on each accepted conversion
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (sample_en) begin
         if (set_c) begin
            flag_q <= 1'b1; // RQ21
         end else if (clr_c) begin
            flag_q <= 1'b0; // RQ21
         end
      end
   end
endmodule : tacc_limit_cmp

// ===== tacc_pkg.sv
// Purpose: shared constants and carriers of the thermal alarm config/compare block
// Assumes: 16-bit registers reached through a pointer, one clock, synchronous reset
// Notes: temperatures are 13-bit two's complement, lsb of 0.0625 degrees
package tacc_pkg;
   // register pointers
   localparam logic [7:0] PTR_CAPS = 8'h00;
   localparam logic [7:0] PTR_CFG = 8'h01;
   localparam logic [7:0] PTR_UPPER = 8'h02;
   localparam logic [7:0] PTR_LOWER = 8'h03;
   localparam logic [7:0] PTR_CRIT = 8'h04;
   localparam logic [7:0] PTR_TEMP = 8'h05;
   localparam logic [7:0] PTR_MFR = 8'h06;
   localparam logic [7:0] PTR_DEV = 8'h07;
   localparam logic [7:0] PTR_RES = 8'h08;
   // configuration field positions
   localparam int CFG_MODE = 0;
   localparam int CFG_POL = 1;
   localparam int CFG_CONLY = 2;
   localparam int CFG_EN = 3;
   localparam int CFG_STS = 4;
   localparam int CFG_CLEAR = 5;
   localparam int CFG_WLOCK = 6;
   localparam int CFG_CLOCK = 7;
   localparam int CFG_POWER_DOWN_BIT = 8;
   localparam int CFG_HYSTERESIS_FIELD_LO = 9;
   // temperature field positions: compare window and status flags
   localparam int TMP_CMP_HI = 12;
   localparam int TMP_CMP_LO = 2;
   localparam int TMP_FLAG_CRIT = 15;
   localparam int TMP_FLAG_UPPER = 14;
   localparam int TMP_FLAG_LOWER = 13;
   // values after reset
   localparam logic [15:0] RST_CFG = 16'h0000;
   localparam logic [15:0] RST_LIMIT = 16'h0000;
   localparam logic [4:0] RST_RES = 5'h0f;
   // hysteresis in quarter degrees per code: none, 6, 12, 24
   localparam logic [4:0] HYSTERESIS_FIELD_Q0 = 5'h00;
   localparam logic [4:0] HYSTERESIS_FIELD_Q1 = 5'h06;
   localparam logic [4:0] HYSTERESIS_FIELD_Q2 = 5'h0c;
   localparam logic [4:0] HYSTERESIS_FIELD_Q3 = 5'h18;
   // fixed capability bits: timeout range 25..35 ms, no event-on-shutdown release
   localparam logic [2:0] CAPS_TOP = 3'h2;
   // limit channels
   localparam int CH_UPPER = 0;
   localparam int CH_LOWER = 1;
   localparam int CH_CRIT = 2;
   localparam int NUM_CH = 3;

   // one register access from the serial front end
   typedef struct packed {
      logic ptr_wr;
      logic wr;
      logic rd;
      logic [7:0] ptr;
      logic [15:0] wdata;
   } tacc_req_t;

   // one finished conversion
   typedef struct packed {
      logic valid;
      logic [12:0] value;
   } tacc_sample_t;
endpackage : tacc_pkg

// ===== thermal_alarm_config_compare_tb.sv
// Purpose: register-level regression of the alarm configuration and limit compare
// Assumes: host model drives every request; alarm wire pulled up on the board
// Notes: temperatures in 1/16 degree steps, upper limit at 25 degrees apart from the negative-limit step and the reset checks
module thermal_alarm_config_compare_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tacc_pkg::*;

   logic sys_clk;
   logic rst_n;
   tacc_req_t acc_req;
   tacc_sample_t conv_sample;
   logic [15:0] acc_rdata_q;
   logic conv_run;
   logic alarm_pin_i;
   logic alarm_pin_o;
   logic alarm_pin_oe;
   int mismatches;
   int checks_done;
   logic [12:0] hy [4] = '{13'h000, 13'h018, 13'h030, 13'h060};

   tacc_alarm_core tacc_alarm_core_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .acc_req(acc_req), .acc_rdata_q(acc_rdata_q),
      .conv_sample(conv_sample), .conv_run(conv_run), .alarm_pin_i(alarm_pin_i),
      .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe)
   );

   tacc_host_model tacc_host_model_inst (
      .sys_clk(sys_clk), .acc_req(acc_req), .acc_rdata_q(acc_rdata_q),
      .conv_sample(conv_sample), .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
      .alarm_pin_i(alarm_pin_i)
   );

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // compare of register words
   task automatic check16(input string name, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, e, s);
      end
   endtask : check16

   // compare of single pins and bits
   task automatic check1(input string name, input logic e, input logic s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", name, e, s);
      end
   endtask : check1

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      tacc_host_model_inst.reg_write(p, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] p, input logic [15:0] e, input string name);
      logic [15:0] d;
      tacc_host_model_inst.reg_read(p, d);
      check16(name, e, d);
   endtask : rd_chk

   task automatic smp(input logic [12:0] v);
      tacc_host_model_inst.put_sample(v);
   endtask : smp

   // wire level is the polarity when asserted, its inverse otherwise
   task automatic pin_chk(input logic asserted, input logic pol);
      check1("alarm wire", asserted ? pol : ~pol, alarm_pin_i);
   endtask : pin_chk

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // hang guard, far beyond the few hundred cycles of the sequence
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end

   // main sequence
   initial begin
      mismatches = 0;
      checks_done = 0;
      rst_n = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(PTR_CFG, 16'h0000, "cfg reset");
      rd_chk(PTR_UPPER, 16'h0000, "upper reset");
      rd_chk(8'h0f, 16'h0000, "unmapped read");
      wr(PTR_LOWER, 16'h1f00);
      wr(PTR_CRIT, 16'h0500);
      wr(PTR_UPPER, 16'h0190);
      rd_chk(PTR_UPPER, 16'h0190, "upper readback");
      wr(PTR_RES, 16'h001f);
      wr(PTR_CFG, 16'h0008);
      // above the limit only in bits below the compare window
      smp(13'h0191);
      pin_chk(1'b0, 1'b0);
      rd_chk(PTR_TEMP, 16'h0191, "temp fine bits");
      smp(13'h0194);
      pin_chk(1'b1, 1'b0);
      rd_chk(PTR_CFG, 16'h0018, "status set");
      rd_chk(PTR_TEMP, 16'h4194, "temp upper flag");
      smp(13'h0190);
      pin_chk(1'b0, 1'b0);
      // every hysteresis code: hold just above, release at limit minus hysteresis
      for (int i = 0; i < 4; i++) begin
         wr(PTR_CFG, {5'h00, 2'(i), 9'h008});
         smp(13'h0194);
         pin_chk(1'b1, 1'b0);
         smp(13'h0194 - hy[i]);
         pin_chk(1'b1, 1'b0);
         smp(13'h0190 - hy[i]);
         pin_chk(1'b0, 1'b0);
      end
      wr(PTR_CFG, 16'h0008);
      // negative limit and readings
      wr(PTR_UPPER, 16'h1ff0);
      smp(13'h1ff4);
      pin_chk(1'b1, 1'b0);
      smp(13'h1fec);
      pin_chk(1'b0, 1'b0);
      wr(PTR_UPPER, 16'h0190);
      // critical only
      wr(PTR_CFG, 16'h000c);
      smp(13'h0194);
      pin_chk(1'b0, 1'b0);
      smp(13'h0504);
      pin_chk(1'b1, 1'b0);
      smp(13'h0100);
      // active-high polarity drives the idle level too
      wr(PTR_CFG, 16'h000a);
      pin_chk(1'b0, 1'b1);
      smp(13'h0194);
      pin_chk(1'b1, 1'b1);
      check1("pin drive", 1'b1, alarm_pin_oe);
      smp(13'h0100);
      // disabled alarm stays released
      wr(PTR_CFG, 16'h0000);
      smp(13'h0194);
      pin_chk(1'b0, 1'b0);
      smp(13'h0100);
      // comparator mode ignores clear and follows the condition
      wr(PTR_CFG, 16'h0008);
      smp(13'h0194);
      wr(PTR_CFG, 16'h0028);
      pin_chk(1'b1, 1'b0);
      smp(13'h0100);
      pin_chk(1'b0, 1'b0);
      // interrupt mode latches until clear
      wr(PTR_CFG, 16'h0009);
      smp(13'h0194);
      pin_chk(1'b1, 1'b0);
      smp(13'h0100);
      pin_chk(1'b1, 1'b0);
      wr(PTR_CFG, 16'h0029);
      pin_chk(1'b0, 1'b0);
      rd_chk(PTR_CFG, 16'h0009, "clear reads zero");
      // clear while above, then the drop to the limit raises a fresh event
      smp(13'h0194);
      wr(PTR_CFG, 16'h0029);
      pin_chk(1'b0, 1'b0);
      smp(13'h0190);
      pin_chk(1'b1, 1'b0);
      wr(PTR_CFG, 16'h0029);
      pin_chk(1'b0, 1'b0);
      // shutdown drops samples but keeps answering
      wr(PTR_CFG, 16'h0108);
      check1("conv run off", 1'b0, conv_run);
      smp(13'h0194);
      pin_chk(1'b0, 1'b0);
      rd_chk(PTR_CFG, 16'h0108, "cfg in shutdown");
      // lock while shut down, then leave shutdown under the lock
      wr(PTR_CFG, 16'h0148);
      wr(PTR_CFG, 16'h0048);
      check1("conv run on", 1'b1, conv_run);
      wr(PTR_CFG, 16'h0744);
      rd_chk(PTR_CFG, 16'h0048, "cfg frozen");
      wr(PTR_UPPER, 16'h0200);
      rd_chk(PTR_UPPER, 16'h0190, "upper locked");
      wr(PTR_LOWER, 16'h0000);
      rd_chk(PTR_LOWER, 16'h1f00, "lower locked");
      wr(PTR_CRIT, 16'h0600);
      rd_chk(PTR_CRIT, 16'h0600, "crit open");
      wr(PTR_CFG, 16'h00c8);
      wr(PTR_CRIT, 16'h0500);
      rd_chk(PTR_CRIT, 16'h0600, "crit locked");
      wr(PTR_CFG, 16'h0008);
      rd_chk(PTR_CFG, 16'h00c8, "locks sticky");
      // only reset releases the locks
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(PTR_CFG, 16'h0000, "cfg after reset");
      wr(PTR_UPPER, 16'h0200);
      rd_chk(PTR_UPPER, 16'h0200, "upper unlocked");
      end_of_test();
   end
endmodule : thermal_alarm_config_compare_tb
